//--- dv/status_host.sv
// host model: turns bench requests into status reads and fault clears
// assumes the bench raises go for one cycle per read
`timescale 1ns/100ps
`default_nettype none
module status_host (
    // clock
    input wire logic ref_clk,
    // bench requests
    input wire logic go,
    input wire logic [7:0] cmd,
    input wire logic bsel,
    input wire logic clr,
    // towards the block
    output var fault_status_pkg::status_read_t rd_req
);
    import fault_status_pkg::*;
    // idle cycles flip the code so a stale valid command never looks valid
    always_ff @(posedge ref_clk) begin
        rd_req.rd_en <= go;
        rd_req.cmd <= go ? cmd : ~cmd;
        rd_req.byte_sel <= bsel;
        rd_req.clear_faults <= clr;
    end
endmodule
`default_nettype wire

//--- dv/testbench.sv
// testbench for the fault status registers
// assumes status_host drives the read port
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import fault_status_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    fault_events_t events = 10'h002;
    status_read_t rd_req;
    logic go = 1'b0;
    logic bsel = 1'b0;
    logic clr = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] rd_data;
    logic [7:0] vflags;
    logic rd_valid;
    logic [15:0] word;
    logic [7:0] expq [$];
    int n_errors = 0;
    int n_tests = 0;
    // {events, low byte, high byte, vout} per case
    logic [33:0] tbl [10] = '{34'h202800000, 34'h102400000, 34'h082208080, 34'h042208080,
        34'h022100000, 34'h012040000, 34'h00a020000, 34'h006010000, 34'h000000800,
        34'h003004000};
    status_host u_host (.ref_clk(ref_clk), .go(go), .cmd(cmd), .bsel(bsel), .clr(clr),
        .rd_req(rd_req));
    fault_status_reporting u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .events(events),
        .rd_req(rd_req), .rd_data(rd_data), .rd_valid(rd_valid),
        .fault_summary_word(word), .output_voltage_fault_flags(vflags));
    initial forever #2 ref_clk = ~ref_clk;
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] c, input logic b, input logic [7:0] e);
        @(posedge ref_clk);
        go <= 1'b1;
        cmd <= c;
        bsel <= b;
        expq.push_back(e);
        @(posedge ref_clk);
        go <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************
    // read monitor
    // ****************
    always @(posedge ref_clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) chk("spare read", 16'h0001, 16'h0000);
            else chk("read data", {8'h00, rd_data}, {8'h00, expq.pop_front()});
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        logic [33:0] t;
        void'($urandom(20513));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("word reset", word, rst_fault_summary_word);
        chk("vout reset", {8'h00, vflags}, {8'h00, rst_output_voltage_fault_flags});
        rd(cmd_fault_summary_word, 1'b0, 8'h00);
        rd(cmd_fault_summary_word, 1'b1, 8'h00);
        rd(cmd_output_voltage_fault_flags, 1'b0, 8'h00);
        // unknown codes read as zero
        repeat (3) rd(8'($urandom_range(255, 123)), 1'b0, 8'h00);
        foreach (tbl[i]) begin
            t = tbl[i];
            @(posedge ref_clk);
            events <= t[33:24];
            repeat (5) @(posedge ref_clk);
            chk("word held", word, {t[15:8], t[23:16]});
            rd(cmd_fault_summary_word, 1'b0, t[23:16]);
            rd(cmd_fault_summary_word, 1'b1, t[15:8]);
            rd(cmd_output_voltage_fault_flags, 1'b0, t[7:0]);
            repeat (3) @(posedge ref_clk);
            events <= 10'h002;
            repeat (5) @(posedge ref_clk);
            // sticky flags stay, live levels drop
            chk("word released", word, {t[15:8] & 8'h80, t[23:16] & 8'hbf});
            chk("vout released", {8'h00, vflags}, {8'h00, t[7:0]});
            clr <= 1'b1;
            @(posedge ref_clk);
            clr <= 1'b0;
            repeat (2) @(posedge ref_clk);
            chk("word cleared", word, 16'h0000);
        end
        // a set arriving on the clear edge must survive it, older flags must not
        @(posedge ref_clk);
        events <= 10'h012;
        @(posedge ref_clk);
        events <= 10'h002;
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        events <= 10'h202;
        @(posedge ref_clk);
        events <= 10'h002;
        repeat (2) @(posedge ref_clk);
        chk("set beats clear", word, 16'h0080);
        rd(cmd_fault_summary_word, 1'b0, 8'h80);
        repeat (4) @(posedge ref_clk);
        chk("pending reads", 16'(expq.size()), 16'h0000);
        stop_test;
    end
    // bound well above the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        stop_test;
    end
endmodule
`default_nettype wire

//--- logic/fault_status_pkg.sv
// fault status package: register offsets, field positions, reset values, event carrier
// assumes the command decoder presents a one-byte command code and byte index
package fault_status_pkg;
    localparam logic [7:0] cmd_fault_summary_word = 8'h79;
    localparam logic [7:0] cmd_output_voltage_fault_flags = 8'h7a;
    localparam logic [15:0] rst_fault_summary_word = 16'h0000;
    localparam logic [7:0] rst_output_voltage_fault_flags = 8'h00;
    // summary word low byte
    localparam int unsigned pos_busy_fault = 7;
    localparam int unsigned pos_not_switching = 6;
    localparam int unsigned pos_overvoltage_entered = 5;
    localparam int unsigned pos_overcurrent_shutdown = 4;
    localparam int unsigned pos_input_undervoltage = 3;
    localparam int unsigned pos_overtemp_shutdown = 2;
    localparam int unsigned pos_comm_logic_fault = 1;
    localparam int unsigned pos_other_fault = 0;
    // summary word high byte (bit numbers within the word)
    localparam int unsigned pos_vout_summary = 15;
    localparam int unsigned pos_iout_summary = 14;
    localparam int unsigned pos_power_good_lost = 11;
    // output-voltage register
    localparam int unsigned pos_ovp_fault = 7;

    typedef struct packed {
        logic busy_fault;
        logic not_switching;
        logic ovp_normal;
        logic ovp_absolute;
        logic overcurrent_shutdown;
        logic overtemp_shutdown;
        logic comm_logic_fault;
        logic other_fault;
        logic power_good_output;
        logic iout_status_any;
    } fault_events_t;

    typedef struct packed {
        logic rd_en;
        logic [7:0] cmd;
        logic byte_sel;
        logic clear_faults;
    } status_read_t;
endpackage

//--- logic/fault_status_reporting.sv
// fault status registers: summary word and output-voltage fault flags
// assumes events and read requests come from logic on ref_clk, except power-good and
// not-switching levels, which arrive from analog blocks and are synchronised here
`timescale 1ns/100ps
`default_nettype none

module fault_status_reporting (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // protection events
    input wire fault_status_pkg::fault_events_t events,
    // read port from command decoder
    input wire fault_status_pkg::status_read_t rd_req,
    // read answer
    output logic [7:0] rd_data,
    output logic rd_valid,
    // full register views
    output logic [15:0] fault_summary_word,
    output logic [7:0] output_voltage_fault_flags
);
    import fault_status_pkg::*;

    // ************************************************************
    // level synchronisers
    // ************************************************************
    // pins from analog blocks; first stage read only by second stage and the not-switching check
    logic pg_meta_q, pg_sync_q, off_meta_q, off_sync_q;
    logic pg_meta_d, pg_sync_d, off_meta_d, off_sync_d;

    always_comb begin
        pg_meta_d = events.power_good_output;
        pg_sync_d = pg_meta_q;
        off_meta_d = events.not_switching;
        off_sync_d = off_meta_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pg_meta_q <= 1'b1;
            pg_sync_q <= 1'b1;
            off_meta_q <= 1'b0;
            off_sync_q <= 1'b0;
        end else begin
            pg_meta_q <= pg_meta_d;
            pg_sync_q <= pg_sync_d;
            off_meta_q <= off_meta_d;
            off_sync_q <= off_sync_d;
        end
    end

    // ************************************************************
    // sticky flags
    // ************************************************************
    // latched flags stay until a clear-faults request; a new event on the clear cycle wins
    logic [15:0] word_q, word_d;
    logic [7:0] vout_q, vout_d;
    logic ovp_entry;

    always_comb begin
        ovp_entry = events.ovp_normal | events.ovp_absolute;
        vout_d = rd_req.clear_faults ? rst_output_voltage_fault_flags : vout_q;
        if (ovp_entry) begin
            vout_d[pos_ovp_fault] = 1'b1;
        end
        word_d = rd_req.clear_faults ? rst_fault_summary_word : word_q;
        if (events.busy_fault) begin
            word_d[pos_busy_fault] = 1'b1;
        end
        word_d[pos_not_switching] = off_sync_q;
        if (ovp_entry) begin
            word_d[pos_overvoltage_entered] = 1'b1;
        end
        if (events.overcurrent_shutdown) begin
            word_d[pos_overcurrent_shutdown] = 1'b1;
        end
        if (events.overtemp_shutdown) begin
            word_d[pos_overtemp_shutdown] = 1'b1;
        end
        if (events.comm_logic_fault) begin
            word_d[pos_comm_logic_fault] = 1'b1;
        end
        if (events.other_fault) begin
            word_d[pos_other_fault] = 1'b1;
        end
        word_d[pos_input_undervoltage] = 1'b0;
        // the vout summary follows the next register state, so it never lags vout_q; the iout summary is registered from its event
        word_d[pos_vout_summary] = |vout_d;
        word_d[pos_iout_summary] = events.iout_status_any;
        word_d[pos_power_good_lost] = ~pg_sync_q;
        word_d[13:12] = 2'h0;
        word_d[10:8] = 3'h0;
        vout_d[6:0] = 7'h00;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            word_q <= rst_fault_summary_word;
            vout_q <= rst_output_voltage_fault_flags;
        end else begin
            word_q <= word_d;
            vout_q <= vout_d;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // unknown command codes answer 0x00 so the decoder never sees stale data
    // the answer lasts one cycle; the byte drops back to 0x00 when no read is asked
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    always_comb begin
        rvalid_d = rd_req.rd_en;
        rdata_d = 8'h00;
        if (rd_req.rd_en) begin
            unique case (rd_req.cmd)
                cmd_fault_summary_word: begin
                    rdata_d = rd_req.byte_sel ? word_q[15:8] : word_q[7:0];
                end
                cmd_output_voltage_fault_flags: begin
                    rdata_d = vout_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign rd_data = rdata_q;
    assign rd_valid = rvalid_q;
    assign fault_summary_word = word_q;
    assign output_voltage_fault_flags = vout_q;

    // ************************************************************
    // checks
    // ************************************************************
    // sticky flags are checked on the registered view, one edge after their event; power-good and not-switching levels against their synchroniser stages
    // clear is taken like an event, so a set on the same edge must survive it
    a_busy_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.busy_fault |=> word_q[pos_busy_fault])
        else $error("busy fault not latched");
    a_off_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 word_q[pos_not_switching] == $past(off_meta_q, 2))
        else $error("not-switching flag does not follow level");
    a_ovp_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (events.ovp_absolute || events.ovp_normal)
        |=> word_q[pos_overvoltage_entered] && vout_q[pos_ovp_fault])
        else $error("overvoltage entry not latched");
    a_oc_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.overcurrent_shutdown |=> word_q[pos_overcurrent_shutdown])
        else $error("overcurrent flag not latched");
    a_ot_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.overtemp_shutdown |=> word_q[pos_overtemp_shutdown])
        else $error("overtemperature flag not latched");
    a_cml_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.comm_logic_fault |=> word_q[pos_comm_logic_fault])
        else $error("comm fault not latched");
    a_other_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
        events.other_fault |=> word_q[pos_other_fault])
        else $error("other fault not latched");
    a_vout_summary: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_q[pos_vout_summary] == (|vout_q))
        else $error("vout summary mismatch");
    a_iout_summary: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> word_q[pos_iout_summary] == $past(events.iout_status_any))
        else $error("iout summary does not follow its source");
    a_pg_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_q[pos_power_good_lost] == !$past(pg_sync_q))
        else $error("power-good loss not mirrored");
    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        word_q[13:12] == 2'h0 && word_q[10:8] == 3'h0 && vout_q[6:0] == 7'h00
        && !word_q[pos_input_undervoltage])
        else $error("reserved bit set");
    a_read_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_req.rd_en && rd_req.cmd == cmd_output_voltage_fault_flags
        |=> rd_valid && rd_data == $past(vout_q))
        else $error("vout read wrong");
    a_word_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_req.rd_en && rd_req.cmd == cmd_fault_summary_word
        |=> rd_valid && rd_data == ($past(rd_req.byte_sel) ? $past(word_q[15:8])
        : $past(word_q[7:0])))
        else $error("summary word read wrong");
    a_unknown_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_req.rd_en && rd_req.cmd != cmd_fault_summary_word
        && rd_req.cmd != cmd_output_voltage_fault_flags
        |=> rd_valid && rd_data == 8'h00)
        else $error("unknown command did not read zero");
    a_clear_vout: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rd_req.clear_faults && !ovp_entry |=> !vout_q[pos_ovp_fault])
        else $error("overvoltage fault not cleared");
    a_valid_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rd_req.rd_en |=> !rd_valid && rd_data == 8'h00)
        else $error("read answer outlived its request");
endmodule

`default_nettype wire
